// ==== core/asc_arbiter.v ====
// Purpose: Hold arbitration, DMA strobes, error NMI, coprocessor glue and
//          reset control for a 16-bit host.
// Assumes: All pins except the CPU I/O access inputs are asynchronous to i_mclk and are synchronised.
// Notes:   The CPU clock edge is modelled by a falling-edge strobe input.
`timescale 1ns/1ns
`default_nettype none
`include "asc_regs.vh"
module asc_arbiter #(
  parameter SYSRST_CYCLES = `ASC_SYSRST_CYCLES,
  parameter DMA_DIV       = `ASC_DMA_DIV
) (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_resetn,
  // Pins from outside
  input  wire       i_reset_in_n,
  input  wire       i_cpu_reset_req_n,
  input  wire       i_cpu_clock_fall,
  input  wire       i_refresh_timer_tick,
  input  wire       i_cpu_hold_ack,
  input  wire       i_dma_hold_req,
  input  wire       i_dma_mem_read_n,
  input  wire       i_refresh_n_in,
  input  wire       i_parity_check_in,
  input  wire       i_channel_check_n,
  input  wire       i_onboard_sel_n,
  input  wire       i_ale,
  input  wire       i_copro_busy_n,
  input  wire       i_copro_error_n,
  input  wire       i_copro_range_sel_n,
  input  wire       i_mio,
  input  wire       i_s1_n,
  input  wire       i_s0_n,
  input  wire       i_a1,
  input  wire       i_bus_master,
  input  wire       i_sys_addr_bit0,
  input  wire       i_io_16bit_sel_n,
  // CPU I/O access, already qualified on this clock
  input  wire [7:0] i_io_addr,
  input  wire [7:0] i_io_wdata,
  input  wire       i_io_wr,
  input  wire       i_io_rd,
  // Outputs
  output reg        o_cpu_hold_req,
  output reg        o_dma_hold_grant,
  output reg        o_refresh_addr_enable_n,
  output wire       o_refresh_n_out,
  output wire       o_refresh_n_oe,
  output reg        o_mem_read_cmd_n,
  output reg        o_dma_cycle_ready,
  output reg        o_dma_clock_en,
  output reg        o_nmi,
  output reg  [1:0] o_io_rdata,
  output wire       o_io_rdata_oe,
  output reg        o_cpu_busy_out_n,
  output reg        o_copro_irq,
  output wire       o_copro_reset_out,
  output reg        o_copro_chip_sel_n,
  output wire       o_int_ack_out_n,
  output reg        o_onboard_sel_latched_n,
  output reg        o_cpu_reset_out,
  output reg        o_sys_reset_out,
  output reg        o_byte_swap_enable_n,
  output reg        o_clocks_stopped,
  output reg  [7:0] o_speed_select
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flops per pin; the first stage feeds only the second.
  localparam NSYNC = 22;
  wire [NSYNC-1:0] raw = {i_reset_in_n, i_cpu_reset_req_n, i_cpu_clock_fall,
    i_refresh_timer_tick, i_cpu_hold_ack, i_dma_hold_req, i_dma_mem_read_n,
    i_refresh_n_in, i_parity_check_in, i_channel_check_n, i_onboard_sel_n,
    i_ale, i_copro_busy_n, i_copro_error_n, i_copro_range_sel_n, i_mio,
    i_s1_n, i_s0_n, i_a1, i_bus_master, i_sys_addr_bit0, i_io_16bit_sel_n};
  // Reset to each pin's idle level, except i_reset_in_n which resets low (asserted), so that no false edge or request follows reset.
  localparam [NSYNC-1:0] SYNC_IDLE = 22'h10dbb1;
  reg [NSYNC-1:0] meta_reg;
  reg [NSYNC-1:0] sync_reg;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= SYNC_IDLE;
      sync_reg <= SYNC_IDLE;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end
  wire rst_in_n = sync_reg[21];
  wire cpurq_n  = sync_reg[20];
  wire cpu_fall = sync_reg[19];
  wire tick     = sync_reg[18];
  wire cpu_hold_ack     = sync_reg[17];
  wire dma_req  = sync_reg[16];
  wire dma_mem_read_n  = sync_reg[15];
  wire rfsh_in  = sync_reg[14];
  wire par_in   = sync_reg[13];
  wire chk_n    = sync_reg[12];
  wire onb_n    = sync_reg[11];
  wire ale      = sync_reg[10];
  wire busy_n   = sync_reg[9];
  wire err_n    = sync_reg[8];
  wire rng_n    = sync_reg[7];
  wire mio      = sync_reg[6];
  wire s1_n     = sync_reg[5];
  wire s0_n     = sync_reg[4];
  wire a1       = sync_reg[3];
  wire bmaster  = sync_reg[2];
  wire sys_addr_bit0     = sync_reg[1];
  wire cs16_n   = sync_reg[0];
  // ----------------------------------------------------------------
  // Status decode and write strobes
  // ----------------------------------------------------------------
  wire [2:0] st  = {mio, s1_n, s0_n};
  wire st_int_ack_out   = (st == 3'b000);
  wire st_io     = (st == 3'b001) || (st == 3'b010);
  wire st_shut   = (st == 3'b100) && !a1;
  reg  tick_d, shut_d, rdcmd_d;
  function wr_hit;
    input [7:0] a;
    begin
      wr_hit = i_io_wr && (i_io_addr == a);
    end
  endfunction
  wire wr_err   = wr_hit(`ASC_ERR_CTRL_ADDR);
  wire wr_spd   = wr_hit(`ASC_SPEED_ADDR);
  wire wr_nmi   = wr_hit(`ASC_NMI_MASK_ADDR);
  wire wr_clrb  = wr_hit(`ASC_CLR_BUSY_ADDR);
  wire wr_cprst = wr_hit(`ASC_COPRO_RST_ADDR);
  assign o_int_ack_out_n = ~st_int_ack_out;
  // ----------------------------------------------------------------
  // Hold arbitration and refresh
  // ----------------------------------------------------------------
  localparam S_IDLE = 4'b0001, S_WAIT = 4'b0010, S_RFSH = 4'b0100, S_DMA = 4'b1000;
  reg [3:0] state_reg;
  reg       rfsh_pend;
  reg [1:0] rcnt;
  reg [7:0] dcnt;
  reg       dma_tick;
  reg       dma_mem_read_d1;
  assign o_refresh_n_out = 1'b0;
  assign o_refresh_n_oe  = (state_reg == S_RFSH);
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= S_IDLE;
      rfsh_pend <= 1'b0;
      rcnt <= 2'd0;
      tick_d <= 1'b0;
      o_cpu_hold_req <= 1'b0;
      o_dma_hold_grant <= 1'b0;
      o_refresh_addr_enable_n <= 1'b1;
    end else begin
      tick_d <= tick;
      if (tick && !tick_d)
        rfsh_pend <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          if ((tick && !tick_d) || rfsh_pend || dma_req) begin
            o_cpu_hold_req <= 1'b1;
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (cpu_hold_ack) begin
            if (rfsh_pend) begin
              state_reg <= S_RFSH;
              rcnt <= 2'd0;
              o_refresh_addr_enable_n <= 1'b0;
            end else if (dma_req) begin
              state_reg <= S_DMA;
              o_dma_hold_grant <= 1'b1;
            end else begin
              o_cpu_hold_req <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        S_RFSH: begin
          if (dma_tick)
            rcnt <= rcnt + 2'd1;
          if (dma_tick && rcnt == 2'd3) begin
            rfsh_pend <= (tick && !tick_d);
            o_refresh_addr_enable_n <= 1'b1;
            state_reg <= S_WAIT;
          end
        end
        default: begin
          if (!dma_req) begin
            o_dma_hold_grant <= 1'b0;
            state_reg <= S_WAIT;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // DMA clock enable, DMA ready and memory read command
  // ----------------------------------------------------------------
  // The divider runs on in sleep so that refresh keeps its timing; only the pin stops.
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dcnt <= 8'd0;
      dma_tick <= 1'b0;
      dma_mem_read_d1 <= 1'b1;
      o_dma_clock_en <= 1'b0;
      o_dma_cycle_ready <= 1'b0;
      o_mem_read_cmd_n <= 1'b1;
    end else begin
      dma_tick <= 1'b0;
      if (dcnt == DMA_DIV[7:0] - 8'd1) begin
        dcnt <= 8'd0;
        dma_tick <= 1'b1;
      end else begin
        dcnt <= dcnt + 8'd1;
      end
      o_dma_clock_en <= dma_tick && !o_clocks_stopped;
      if (dma_tick)
        dma_mem_read_d1 <= dma_mem_read_n || !o_dma_hold_grant;
      o_dma_cycle_ready <= o_dma_hold_grant;
      if (state_reg == S_RFSH)
        o_mem_read_cmd_n <= !(rcnt == 2'd1 || rcnt == 2'd2);
      else if (o_dma_hold_grant)
        o_mem_read_cmd_n <= dma_mem_read_d1 | dma_mem_read_n;
      else
        o_mem_read_cmd_n <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Error control, NMI and registers
  // ----------------------------------------------------------------
  reg par_en, chk_en, par_lat, chk_lat, nmi_mask, par_arm;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      par_en <= 1'b0;
      chk_en <= 1'b0;
      par_lat <= 1'b0;
      chk_lat <= 1'b0;
      par_arm <= 1'b0;
      rdcmd_d <= 1'b1;
      nmi_mask <= `ASC_NMI_MASK_RST;
      o_speed_select <= `ASC_SPEED_RST;
      o_onboard_sel_latched_n <= 1'b1;
      o_nmi <= 1'b0;
      o_io_rdata <= 2'b00;
    end else if (o_sys_reset_out) begin
      par_en <= 1'b0;
      chk_en <= 1'b0;
      nmi_mask <= `ASC_NMI_MASK_RST;
      par_lat <= 1'b0;
      chk_lat <= 1'b0;
      par_arm <= 1'b0;
      o_speed_select <= (o_speed_select & 8'hb3) | 8'h80;
      o_nmi <= 1'b0;
    end else begin
      if (ale || cpu_hold_ack)
        o_onboard_sel_latched_n <= onb_n;
      rdcmd_d <= o_mem_read_cmd_n;
      if (o_mem_read_cmd_n && !rdcmd_d && !o_onboard_sel_latched_n)
        par_arm <= 1'b1;
      if (par_arm && cpu_fall)
        par_arm <= 1'b0;
      if (par_arm && cpu_fall && par_in)
        par_lat <= 1'b1;
      else if (wr_err && !i_io_wdata[`ASC_ERR_PAR_EN_BIT])
        par_lat <= 1'b0;
      if (chk_en && !chk_n)
        chk_lat <= 1'b1;
      else if (wr_err && !i_io_wdata[`ASC_ERR_CHK_EN_BIT])
        chk_lat <= 1'b0;
      if (wr_err) begin
        par_en <= i_io_wdata[`ASC_ERR_PAR_EN_BIT];
        chk_en <= i_io_wdata[`ASC_ERR_CHK_EN_BIT];
      end
      if (wr_nmi)
        nmi_mask <= i_io_wdata[`ASC_NMI_MASK_BIT];
      if (wr_spd && !o_speed_select[`ASC_SPD_LOCK_BIT] && !i_io_wdata[7])
        o_speed_select <= i_io_wdata;
      else if (wr_spd)
        o_speed_select[`ASC_SPD_LOCK_BIT] <= i_io_wdata[`ASC_SPD_LOCK_BIT];
      o_nmi <= !nmi_mask && ((par_en && par_lat) || chk_lat);
      o_io_rdata <= {par_lat, chk_lat};
    end
  end
  assign o_io_rdata_oe = i_io_rd && (i_io_addr == `ASC_ERR_CTRL_ADDR);
  // ----------------------------------------------------------------
  // Coprocessor interface and byte swap
  // ----------------------------------------------------------------
  reg busy_lat, cp_rst_pulse, cpurq_d;
  localparam [2:0] CPRST_LAST = `ASC_COPRO_RST_CYC - 1;
  reg [2:0] cp_cnt;
  assign o_copro_reset_out = o_sys_reset_out || cp_rst_pulse;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_lat <= 1'b0;
      cp_rst_pulse <= 1'b0;
      cpurq_d <= 1'b1;
      cp_cnt <= 3'd0;
      o_copro_irq <= 1'b0;
      o_cpu_busy_out_n <= 1'b1;
      o_copro_chip_sel_n <= 1'b1;
      o_byte_swap_enable_n <= 1'b1;
      o_clocks_stopped <= 1'b0;
    end else begin
      if (wr_cprst) begin
        cp_rst_pulse <= 1'b1;
        cp_cnt <= 3'd0;
      end else if (cp_rst_pulse) begin
        cp_cnt <= cp_cnt + 3'd1;
        if (cp_cnt == CPRST_LAST)
          cp_rst_pulse <= 1'b0;
      end
      if (!err_n && !busy_n)
        busy_lat <= 1'b1;
      else if (wr_clrb || o_copro_reset_out)
        busy_lat <= 1'b0;
      o_copro_irq <= (!err_n && !busy_n) || (o_copro_irq && !err_n);
      o_cpu_busy_out_n <= busy_n && !busy_lat && !(!err_n && !busy_n);
      o_copro_chip_sel_n <= !(!rng_n && i_io_addr[3] && !st_int_ack_out && st_io);
      o_byte_swap_enable_n <= !(bmaster && st_io && sys_addr_bit0 && cs16_n);
      if (o_speed_select[`ASC_SPD_STOP_BIT] && cpu_hold_ack)
        o_clocks_stopped <= 1'b1;
      else if (cpurq_n && !cpurq_d)
        o_clocks_stopped <= 1'b0;
      cpurq_d <= cpurq_n;
    end
  end
  // ----------------------------------------------------------------
  // Reset control
  // ----------------------------------------------------------------
  reg [5:0] sys_cnt;
  reg [2:0] cpu_cnt;
  localparam [2:0] CPURST_LEN = `ASC_CPURST_DMACLKS;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_cnt <= 6'd0;
      cpu_cnt <= 3'd0;
      shut_d <= 1'b0;
      o_sys_reset_out <= 1'b1;
      o_cpu_reset_out <= 1'b1;
    end else begin
      shut_d <= st_shut;
      if (!rst_in_n) begin
        sys_cnt <= SYSRST_CYCLES[5:0];
      end else if (sys_cnt != 6'd0 && cpu_fall) begin
        sys_cnt <= sys_cnt - 6'd1;
      end
      o_sys_reset_out <= !rst_in_n || sys_cnt != 6'd0;
      if ((!cpurq_n && !o_clocks_stopped) || (st_shut && !shut_d))
        cpu_cnt <= CPURST_LEN;
      else if (cpu_cnt != 3'd0 && dma_tick)
        cpu_cnt <= cpu_cnt - 3'd1;
      o_cpu_reset_out <= !rst_in_n || sys_cnt != 6'd0 || cpu_cnt != 3'd0;
    end
  end
endmodule // asc_arbiter
`default_nettype wire

// ==== core/asc_regs.vh ====
// Purpose: Constants for the system arbitration and control block.
// Assumes: 25 MHz master clock; I/O addresses are 8 bits wide.
// Notes:   Bit positions, offsets, reset values and counts live here.
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASC_ERR_CTRL_ADDR   8'h61
`define ASC_SPEED_ADDR      8'h63
`define ASC_NMI_MASK_ADDR   8'h70
`define ASC_CLR_BUSY_ADDR   8'hf0
`define ASC_COPRO_RST_ADDR  8'hf1
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASC_ERR_PAR_EN_BIT  2
`define ASC_ERR_CHK_EN_BIT  3
`define ASC_ERR_CHK_STS_BIT 6
`define ASC_ERR_PAR_STS_BIT 7
`define ASC_SPD_LOCK_BIT    2
`define ASC_SPD_STOP_BIT    6
`define ASC_NMI_MASK_BIT    7
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define ASC_SPEED_RST       8'h80
`define ASC_NMI_MASK_RST    1'b1
`define ASC_SYSRST_CYCLES   30
`define ASC_CPURST_DMACLKS  4
`define ASC_DMA_DIV         8
`define ASC_COPRO_RST_CYC   4
`endif

// ==== verification/asc_arbiter_monitor.sv ====
// Purpose: Concurrent checks on the ports of the arbitration block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
`default_nettype none
`include "asc_regs.vh"
module asc_arbiter_monitor #(
  parameter int DMA_DIV = 8
) (
  // Clock, reset and inputs
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_refresh_timer_tick,
  input wire logic [7:0] i_io_addr,
  input wire logic       i_io_wr,
  input wire logic       i_io_rd,
  // Outputs watched
  input wire logic       o_cpu_hold_req,
  input wire logic       o_dma_hold_grant,
  input wire logic       o_refresh_addr_enable_n,
  input wire logic       o_refresh_n_out,
  input wire logic       o_refresh_n_oe,
  input wire logic       o_io_rdata_oe,
  input wire logic       o_cpu_busy_out_n,
  input wire logic       o_copro_irq,
  input wire logic       o_copro_reset_out,
  input wire logic       o_cpu_reset_out,
  input wire logic       o_sys_reset_out
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ----
  // Helper logic
  // ----
  // A counter, since a repetition as long as the reset pulse would unroll badly.
  logic [7:0] rst_len_reg;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) rst_len_reg <= 8'h00;
    else if (!o_cpu_reset_out) rst_len_reg <= 8'h00;
    else if (rst_len_reg != 8'hff) rst_len_reg <= rst_len_reg + 8'h01;
  end
  sequence seq_copro_pulse; o_copro_reset_out [*4]; endsequence
  sequence seq_busy_latched; ##[0:3] !o_cpu_busy_out_n; endsequence
  // ----
  // Assertions
  // ----
  AST_HOLD_ON_TICK: assert property ($rose(i_refresh_timer_tick) && !o_sys_reset_out
    |-> ##[1:6] o_cpu_hold_req) else $error("hold request missing after tick");
  AST_REFRESH_SIGNALS: assert property (o_refresh_n_oe
    |-> !o_refresh_addr_enable_n && o_cpu_hold_req) else $error("refresh signals wrong");
  AST_REFRESH_LOW_ONLY: assert property (o_refresh_n_out == 1'b0)
    else $error("refresh line driven high");
  AST_GRANT_IN_HOLD: assert property (o_dma_hold_grant |-> o_cpu_hold_req)
    else $error("grant without hold request");
  AST_REFRESH_FIRST: assert property (o_refresh_n_oe |-> !o_dma_hold_grant)
    else $error("refresh and grant together");
  AST_READ_DRIVE: assert property (o_io_rdata_oe == (i_io_rd && i_io_addr == 8'h61))
    else $error("read drive enable wrong");
  AST_SYS_WITH_CPU: assert property (o_sys_reset_out |-> o_cpu_reset_out)
    else $error("system reset without cpu reset");
  AST_COPRO_SYS: assert property (o_sys_reset_out |-> o_copro_reset_out)
    else $error("coprocessor reset missing in system reset");
  AST_COPRO_WRITE: assert property (i_io_wr && i_io_addr == 8'hf1 && !o_sys_reset_out
    |=> seq_copro_pulse) else $error("coprocessor reset pulse short");
  AST_CPU_RESET_LEN: assert property ($fell(o_cpu_reset_out)
    |-> rst_len_reg >= 3 * DMA_DIV) else $error("cpu reset too short");
  AST_IRQ_LATCH: assert property ($rose(o_copro_irq) |-> seq_busy_latched)
    else $error("busy not latched low on error");
endmodule // asc_arbiter_monitor
bind asc_arbiter asc_arbiter_monitor #(.DMA_DIV(DMA_DIV)) u_asc_arbiter_monitor (
  .i_mclk, .i_resetn, .i_refresh_timer_tick, .i_io_addr, .i_io_wr, .i_io_rd,
  .o_cpu_hold_req, .o_dma_hold_grant, .o_refresh_addr_enable_n, .o_refresh_n_out,
  .o_refresh_n_oe, .o_io_rdata_oe, .o_cpu_busy_out_n, .o_copro_irq, .o_copro_reset_out,
  .o_cpu_reset_out, .o_sys_reset_out);
`default_nettype wire

// ==== verification/asc_cpu_model.sv ====
// Purpose: Behavioural CPU answering hold requests.
// Assumes: Same clock as the block.
// Notes:   Prompt or slow acknowledge, chosen by the bench.
`timescale 1ns/1ns
`default_nettype none
module asc_cpu_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // Control and handshake
  input  wire logic i_slow,
  input  wire logic i_cpu_hold_req,
  output var  logic o_cpu_hold_ack
);
  logic [3:0] wait_reg;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg       <= 4'h0;
      o_cpu_hold_ack <= 1'b0;
    end else if (!i_cpu_hold_req) begin
      wait_reg       <= 4'h0;
      o_cpu_hold_ack <= 1'b0;
    end else if (wait_reg == (i_slow ? 4'h6 : 4'h1)) begin
      o_cpu_hold_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // asc_cpu_model
`default_nettype wire

// ==== verification/test_at_system_arbitration_control.sv ====
// Purpose: Self-checking bench for the arbitration and control block.
// Assumes: DMA_DIV cut to 2; a CPU clock fall is marked every second clock.
// Notes:   Expected values are queued; a second process compares them.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin exp_q.push_back(e); seen = (g); tag = n; ->probe; #1; end
`define WT(c) begin k = 0; while (!(c) && k < 200) begin @(negedge i_mclk); k++; end \
  if (k >= 200) n_errors++; end
module test_at_system_arbitration_control;
  logic i_mclk, i_resetn, i_reset_in_n, i_cpu_reset_req_n, i_cpu_clock_fall, i_ale, i_a1;
  logic i_refresh_timer_tick, i_dma_hold_req, i_dma_mem_read_n, i_refresh_n_in, i_mio;
  logic i_parity_check_in, i_channel_check_n, i_onboard_sel_n, i_copro_busy_n, i_s1_n;
  logic i_copro_error_n, i_copro_range_sel_n, i_s0_n, i_bus_master, i_sys_addr_bit0;
  logic i_io_16bit_sel_n, i_io_wr, i_io_rd, slow, held, cs, bs, rst, oe, ia;
  logic [7:0] i_io_addr, i_io_wdata, seen, d;
  logic [1:0] rd;
  wire logic i_cpu_hold_ack, o_cpu_hold_req, o_dma_hold_grant, o_refresh_addr_enable_n;
  wire logic o_refresh_n_out, o_refresh_n_oe, o_mem_read_cmd_n, o_dma_cycle_ready, o_nmi;
  wire logic o_dma_clock_en, o_io_rdata_oe, o_cpu_busy_out_n, o_copro_irq, o_sys_reset_out;
  wire logic o_copro_reset_out, o_copro_chip_sel_n, o_int_ack_out_n, o_cpu_reset_out;
  wire logic o_onboard_sel_latched_n, o_byte_swap_enable_n, o_clocks_stopped;
  wire logic [1:0] o_io_rdata;
  wire logic [7:0] o_speed_select;
  logic [7:0] exp_q[$];
  logic [2:0] codes[5] = '{3'b000, 3'b001, 3'b010, 3'b101, 3'b110};
  string tag;
  event probe;
  int n_errors = 0, samples_checked = 0, k;
  asc_arbiter #(.DMA_DIV(2)) u_asc_arbiter (.i_mclk, .i_resetn, .i_reset_in_n,
    .i_cpu_reset_req_n, .i_cpu_clock_fall, .i_refresh_timer_tick, .i_cpu_hold_ack,
    .i_dma_hold_req, .i_dma_mem_read_n, .i_refresh_n_in, .i_parity_check_in,
    .i_channel_check_n, .i_onboard_sel_n, .i_ale, .i_copro_busy_n, .i_copro_error_n,
    .i_copro_range_sel_n, .i_mio, .i_s1_n, .i_s0_n, .i_a1, .i_bus_master, .i_sys_addr_bit0,
    .i_io_16bit_sel_n, .i_io_addr, .i_io_wdata, .i_io_wr, .i_io_rd, .o_cpu_hold_req,
    .o_dma_hold_grant, .o_refresh_addr_enable_n, .o_refresh_n_out, .o_refresh_n_oe,
    .o_mem_read_cmd_n, .o_dma_cycle_ready, .o_dma_clock_en, .o_nmi, .o_io_rdata,
    .o_io_rdata_oe, .o_cpu_busy_out_n, .o_copro_irq, .o_copro_reset_out, .o_copro_chip_sel_n,
    .o_int_ack_out_n, .o_onboard_sel_latched_n, .o_cpu_reset_out, .o_sys_reset_out,
    .o_byte_swap_enable_n, .o_clocks_stopped, .o_speed_select);
  asc_cpu_model u_asc_cpu_model (.i_mclk, .i_resetn, .i_slow(slow),
    .i_cpu_hold_req(o_cpu_hold_req), .o_cpu_hold_ack(i_cpu_hold_ack));
  // ----
  // Clock, markers, checker and watchdog
  // ----
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) i_cpu_clock_fall <= !i_cpu_clock_fall;
  always @(posedge i_mclk) if (!o_cpu_hold_req) held <= 1'b0;
  always @(probe) begin
    samples_checked++;
    d = exp_q.pop_front();
    if (d !== seen) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", tag, d, seen);
    end
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Bus and cycle tasks
  // ----
  task automatic io_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_mclk); i_io_addr = a; i_io_wdata = v; i_io_wr = 1'b1;
    @(negedge i_mclk); i_io_wr = 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask
  task automatic io_rd(input logic [7:0] a);
    @(negedge i_mclk); i_io_addr = a; i_io_rd = 1'b1; #1 oe = o_io_rdata_oe;
    @(negedge i_mclk); i_io_rd = 1'b0; rd = o_io_rdata;
  endtask
  // Cheaper than per-field waits: one status cycle, then sample the decoded outputs.
  task automatic cyc(input logic [2:0] st, input logic [7:0] a);
    @(negedge i_mclk); {i_mio, i_s1_n, i_s0_n} = st; i_io_addr = a; i_ale = 1'b1;
    @(negedge i_mclk); i_ale = 1'b0;
    repeat (5) @(negedge i_mclk);
    cs = o_copro_chip_sel_n; bs = o_byte_swap_enable_n; rst = o_cpu_reset_out;
    ia = o_int_ack_out_n;
    {i_mio, i_s1_n, i_s0_n} = 3'b011;
    repeat (20) @(negedge i_mclk);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h974da6de));
    {i_resetn, i_reset_in_n, i_refresh_timer_tick, i_dma_hold_req, i_ale, i_a1} = '0;
    {i_parity_check_in, i_bus_master, i_sys_addr_bit0, i_io_wr, i_io_rd, slow} = '0;
    {i_cpu_reset_req_n, i_dma_mem_read_n, i_refresh_n_in, i_channel_check_n} = '1;
    {i_onboard_sel_n, i_copro_busy_n, i_copro_error_n, i_copro_range_sel_n} = '1;
    {i_mio, i_s1_n, i_s0_n, i_io_16bit_sel_n, i_cpu_clock_fall} = 5'b01110;
    i_io_addr = 8'h00; i_io_wdata = 8'h00;
    repeat (8) @(negedge i_mclk);
    `CHK("speed_reset", 8'h80, o_speed_select)
    i_resetn = 1'b1;
    repeat (10) @(negedge i_mclk);
    `CHK("sys_reset_held", 1, o_sys_reset_out)
    i_reset_in_n = 1'b1;
    `WT(!o_sys_reset_out)
    `CHK("sys_reset_len", 1, k >= 58)
    `CHK("nmi_reset", 0, o_nmi)
    // Refresh alone, then refresh with DMA pending and a slow acknowledge.
    for (int j = 0; j < 2; j++) begin
      slow = j[0];
      @(negedge i_mclk); i_refresh_timer_tick = 1'b1; i_dma_hold_req = j[0];
      `WT(o_refresh_n_oe)
      held = 1'b1;
      `CHK("refresh_addr_en", 0, o_refresh_addr_enable_n)
      `CHK("grant_in_refresh", 0, o_dma_hold_grant)
      if (j == 1) begin
        `WT(o_dma_hold_grant)
        `CHK("dma_grant", 1, o_dma_hold_grant)
        `CHK("hold_kept", 1, held)
        i_dma_mem_read_n = 1'b0;
        `WT(!o_mem_read_cmd_n)
        `CHK("read_delay", 1, k >= 2)
        `WT(o_dma_cycle_ready)
        `CHK("dma_ready", 1, o_dma_cycle_ready)
        i_dma_mem_read_n = 1'b1;
      end
      i_refresh_timer_tick = 1'b0; i_dma_hold_req = 1'b0;
      `WT(!o_cpu_hold_req)
      `CHK("hold_drop", 0, o_cpu_hold_req)
    end
    // Channel check, masked then unmasked, and clearing by enable toggle.
    io_wr(8'h61, 8'h0c);
    i_channel_check_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    `CHK("nmi_masked", 0, o_nmi)
    io_wr(8'h70, 8'h00);
    `WT(o_nmi)
    `CHK("nmi_channel", 1, o_nmi)
    i_channel_check_n = 1'b1;
    io_rd(8'h61);
    `CHK("status_read", 2'b01, rd)
    `CHK("status_drive", 1, oe)
    io_wr(8'h61, 8'h04);
    io_wr(8'h61, 8'h0c);
    io_rd(8'h61);
    `CHK("status_cleared", 2'b00, rd)
    // Parity error on an on-board refresh read, then clearing by enable toggle.
    {i_onboard_sel_n, i_parity_check_in} = 2'b01;
    i_refresh_timer_tick = 1'b1;
    `WT(!o_mem_read_cmd_n)
    `CHK("onboard_latched", 0, o_onboard_sel_latched_n)
    i_refresh_timer_tick = 1'b0;
    `WT(o_nmi)
    io_rd(8'h61);
    `CHK("parity_read", 2'b10, rd)
    {i_onboard_sel_n, i_parity_check_in} = 2'b10;
    io_wr(8'h61, 8'h08);
    io_wr(8'h61, 8'h0c);
    `CHK("parity_cleared", 0, o_nmi)
    // Coprocessor error latch, release and reset.
    {i_copro_busy_n, i_copro_error_n} = 2'b00;
    `WT(o_copro_irq)
    `CHK("copro_irq", 1, o_copro_irq)
    {i_copro_busy_n, i_copro_error_n} = 2'b11;
    repeat (6) @(negedge i_mclk);
    `CHK("irq_off", 0, o_copro_irq)
    `CHK("busy_latched", 0, o_cpu_busy_out_n)
    io_wr(8'hf0, 8'($urandom));
    `CHK("busy_follows", 1, o_cpu_busy_out_n)
    io_wr(8'hf1, 8'h00);
    // Status decode drives chip select, shutdown and byte swap.
    i_copro_range_sel_n = 1'b0;
    for (int j = 0; j < 5; j++) begin
      cyc(codes[j], 8'hf8);
      `CHK("chip_sel", !(codes[j] == 3'b001 || codes[j] == 3'b010), cs)
      `CHK("int_ack", codes[j] != 3'b000, ia)
    end
    cyc(3'b010, 8'he0);
    `CHK("chip_sel_low_range", 1, cs)
    for (int j = 0; j < 2; j++) begin
      i_a1 = j[0];
      cyc(3'b100, 8'h00);
      `CHK("shutdown_reset", !j[0], rst)
    end
    {i_bus_master, i_sys_addr_bit0} = 2'b11;
    for (int j = 0; j < 2; j++) begin
      i_io_16bit_sel_n = !j[0];
      cyc(3'b010, 8'h10);
      `CHK("byte_swap", j[0], bs)
    end
    i_bus_master = 1'b0;
    @(negedge i_mclk); i_cpu_reset_req_n = 1'b0;
    repeat (2) @(negedge i_mclk); i_cpu_reset_req_n = 1'b1;
    `WT(o_cpu_reset_out)
    `CHK("cpu_reset_req", 1, o_cpu_reset_out)
    `WT(!o_cpu_reset_out)
    // Sleep, a refused speed write, an unmapped place, then wake-up.
    io_wr(8'h63, 8'h40);
    `CHK("speed_write", 8'h40, o_speed_select)
    i_refresh_timer_tick = 1'b1;
    `WT(o_clocks_stopped)
    `CHK("sleep", 1, o_clocks_stopped)
    i_refresh_timer_tick = 1'b0;
    k = 0;
    repeat (20) @(negedge i_mclk) k += o_dma_clock_en;
    `CHK("dma_clock_stopped", 0, k)
    d = 8'($urandom) | 8'h80;
    io_wr(8'h63, d);
    `CHK("speed_refused", 8'h40 | (d & 8'h04), o_speed_select)
    io_wr(8'h55, 8'($urandom));
    io_rd(8'h55);
    `CHK("unmapped_drive", 0, oe)
    @(negedge i_mclk); i_cpu_reset_req_n = 1'b0;
    repeat (2) @(negedge i_mclk); i_cpu_reset_req_n = 1'b1;
    `WT(!o_clocks_stopped)
    `CHK("wake", 0, o_clocks_stopped)
    `CHK("wake_no_reset", 0, o_cpu_reset_out)
    report_and_stop();
  end
endmodule // test_at_system_arbitration_control
`default_nettype wire
